// [src/psd_pkg.sv]
package psd_pkg;

  // ************************************************************
  // channel select and feedback divider
  // ************************************************************
  localparam int SEL_W = 9;
  localparam logic [SEL_W-1:0] SEL_CODE_ZERO = 9'h000;
  localparam logic [SEL_W-1:0] SEL_CODE_ONE = 9'h001;
  localparam logic [SEL_W-1:0] N_FOR_CODE_ZERO = 9'h002;
  localparam logic [SEL_W-1:0] N_FOR_CODE_ONE = 9'h003;
  localparam logic [SEL_W-1:0] N_STEP_ONE = 9'h001;
  localparam logic [SEL_W-1:0] N_COUNT_ZERO = 9'h000;

  // ************************************************************
  // reference chain: half-rate stage, then 512 or 1024
  // ************************************************************
  localparam int PRE_W = 10;
  localparam logic [PRE_W-1:0] PRE_LAST_FAST = 10'h1ff;
  localparam logic [PRE_W-1:0] PRE_LAST_SLOW = 10'h3ff;
  localparam logic [PRE_W-1:0] PRE_ONE = 10'h001;
  localparam logic [PRE_W-1:0] PRE_ZERO = 10'h000;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_PERIOD_NS = 4;
  localparam int LOCK_TOL_NS = 40;
  localparam int LOCK_CNT_W = 4;
  localparam logic [LOCK_CNT_W-1:0] LOCK_TOL_CYC =
    LOCK_CNT_W'((LOCK_TOL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [LOCK_CNT_W-1:0] LOCK_CNT_ONE = 4'h1;
  localparam logic [LOCK_CNT_W-1:0] LOCK_CNT_ZERO = 4'h0;

  // ************************************************************
  // register map
  // ************************************************************
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_STATE = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_INT_STAT = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_INT_EN = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_INT_CLR = 8'h10;
  localparam int CTRL_EN_BIT = 0;
  localparam logic CTRL_EN_RST = 1'b1;
  localparam int ST_N_LSB = 0;
  localparam int ST_LOCK_BIT = 16;
  localparam int ST_UP_BIT = 17;
  localparam int ST_DN_BIT = 18;
  localparam int ST_RATE_BIT = 19;
  localparam int INT_W = 2;
  localparam int INT_LOSS_BIT = 0;
  localparam int INT_GAIN_BIT = 1;
  localparam logic [INT_W-1:0] INT_NONE = 2'h0;
  localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;

  // phase detector pump state
  typedef struct packed {
    logic up;
    logic dn;
  } psd_pfd_t;

  // channel code to division ratio; the two lowest codes are exceptions
  function automatic logic [SEL_W-1:0] psd_div_n(input logic [SEL_W-1:0] code);
    logic [SEL_W-1:0] n;
    n = code;
    if (code == SEL_CODE_ZERO) begin
      n = N_FOR_CODE_ZERO;
    end else if (code == SEL_CODE_ONE) begin
      n = N_FOR_CODE_ONE;
    end
    return n;
  endfunction

endpackage

// [src/psd_fb_div.sv]
`timescale 1ns/10ps
module psd_fb_div
  import psd_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic step,
  input wire logic [SEL_W-1:0] n,
  output logic tick
);

  logic [SEL_W-1:0] cnt_q;
  logic [SEL_W-1:0] cnt_d;
  logic at_end;
  logic tick_d;

  // ************************************************************
  // down counter, reloads n-1 on its last feedback edge
  // ************************************************************
  // a new ratio takes effect at the next reload, so no short cycle appears
  assign at_end = (cnt_q == N_COUNT_ZERO);
  assign tick_d = step & at_end;
  assign cnt_d = !step ? cnt_q : (at_end ? (n - N_STEP_ONE) : (cnt_q - N_STEP_ONE));

  // counter and registered tick
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q <= N_COUNT_ZERO;
      tick <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tick <= tick_d;
    end
  end

endmodule

// [src/psd_top.sv]
// The address-and-strobe port and the address map are this design's own decisions.
`timescale 1ns/10ps
module psd_top
  import psd_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic OSC_AMP_INPUT,
  input wire logic FEEDBACK_IN,
  input wire logic [SEL_W-1:0] CHANNEL_SELECT_INPUTS,
  input wire logic REFERENCE_RATE_SELECT,
  input wire logic [ADDR_W-1:0] REG_ADDR,
  input wire logic [DATA_W-1:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [DATA_W-1:0] REG_RDATA,
  output logic OSC_AMP_OUTPUT,
  output logic HALF_OSC_OUTPUT,
  output logic PHASE_ERROR_O,
  output logic PHASE_ERROR_OE,
  output logic LOCK_INDICATOR,
  output logic IRQ
);

  // ************************************************************
  // input edge detection
  // ************************************************************
  localparam int NUM_IN = 2;
  localparam int IN_OSC = 0;
  localparam int IN_FB = 1;

  logic [NUM_IN-1:0] in_now;
  logic [NUM_IN-1:0] in_q;
  logic [NUM_IN-1:0] in_rise;
  logic osc_rise;
  logic fb_rise;

  assign in_now = {FEEDBACK_IN, OSC_AMP_INPUT};

  // pins are already synchronous, so one stage is enough for edges
  genvar gi;
  generate
    for (gi = 0; gi < NUM_IN; gi++) begin : g_edge
      always_ff @(posedge REF_CLK) begin
        if (RST) begin
          in_q[gi] <= 1'b0;
        end else begin
          in_q[gi] <= in_now[gi];
        end
      end
      assign in_rise[gi] = in_now[gi] & ~in_q[gi];
    end
  endgenerate

  assign osc_rise = in_rise[IN_OSC];
  assign fb_rise = in_rise[IN_FB];

  // ************************************************************
  // oscillator amplifier and half-rate stage
  // ************************************************************
  logic half_q;
  logic half_rise;
  logic osc_out_q;

  assign half_rise = osc_rise & ~half_q;

  // amplifier inverts the oscillator; half stage toggles on rising edges
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      half_q <= 1'b0;
      osc_out_q <= 1'b1;
    end else begin
      osc_out_q <= ~OSC_AMP_INPUT;
      if (osc_rise) begin
        half_q <= ~half_q;
      end
    end
  end

  // ************************************************************
  // reference prescaler
  // ************************************************************
  logic [PRE_W-1:0] pre_q;
  logic [PRE_W-1:0] pre_last;
  logic pre_wrap;
  logic ref_tick_q;

  // rate select high gives the short chain and the faster reference
  assign pre_last = REFERENCE_RATE_SELECT ? PRE_LAST_FAST : PRE_LAST_SLOW;
  assign pre_wrap = half_rise & (pre_q >= pre_last);

  // counts half-rate cycles; the compare tolerates a mid-count rate change
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      pre_q <= PRE_ZERO;
      ref_tick_q <= 1'b0;
    end else begin
      ref_tick_q <= pre_wrap;
      if (half_rise) begin
        pre_q <= pre_wrap ? PRE_ZERO : (pre_q + PRE_ONE);
      end
    end
  end

  // ************************************************************
  // feedback divider
  // ************************************************************
  logic [SEL_W-1:0] div_n;
  logic fb_tick;

  // a floating pin is pulled low outside, so it simply decodes as zero
  assign div_n = psd_div_n(CHANNEL_SELECT_INPUTS);

  psd_fb_div u_fb_div (
    .clk(REF_CLK),
    .rst(RST),
    .step(fb_rise),
    .n(div_n),
    .tick(fb_tick)
  );

  // ************************************************************
  // registers
  // ************************************************************
  logic ctrl_en_q;
  logic [INT_W-1:0] int_stat_q;
  logic [INT_W-1:0] int_stat_d;
  logic [INT_W-1:0] int_en_q;
  logic [INT_W-1:0] int_clr;
  logic [INT_W-1:0] int_evt;
  logic wr_ctrl;
  logic wr_en;
  logic wr_clr;
  logic [DATA_W-1:0] rd_mux;

  assign wr_ctrl = REG_WR & (REG_ADDR == OFS_CTRL);
  assign wr_en = REG_WR & (REG_ADDR == OFS_INT_EN);
  assign wr_clr = REG_WR & (REG_ADDR == OFS_INT_CLR);
  assign int_clr = wr_clr ? REG_WDATA[INT_W-1:0] : INT_NONE;
  // a new event in the clearing cycle survives the clear
  assign int_stat_d = (int_stat_q & ~int_clr) | int_evt;

  // ************************************************************
  // phase/frequency detector
  // ************************************************************
  psd_pfd_t pfd_q;
  psd_pfd_t pfd_d;
  logic pfd_both;
  logic pfd_busy;
  logic out_q;
  logic oe_q;

  // edges that meet in one cycle cancel, so the pumps stay off
  assign pfd_both = (pfd_q.up | ref_tick_q) & (pfd_q.dn | fb_tick);
  assign pfd_d.up = (pfd_q.up | ref_tick_q) & ~pfd_both;
  assign pfd_d.dn = (pfd_q.dn | fb_tick) & ~pfd_both;
  assign pfd_busy = pfd_q.up | pfd_q.dn;

  // up drives high, down drives low, idle releases the pin
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      pfd_q <= '0;
      out_q <= 1'b0;
      oe_q <= 1'b0;
    end else begin
      pfd_q <= pfd_d;
      out_q <= pfd_d.up;
      oe_q <= ctrl_en_q & (pfd_d.up | pfd_d.dn);
    end
  end

  // ************************************************************
  // lock detector
  // ************************************************************
  logic [LOCK_CNT_W-1:0] err_cnt_q;
  logic [LOCK_CNT_W-1:0] err_cnt_d;
  logic lock_q;
  logic lock_d;

  // short pump pulses are normal tracking; only long ones mean lost lock
  assign err_cnt_d = !pfd_busy ? LOCK_CNT_ZERO :
    ((err_cnt_q == LOCK_TOL_CYC) ? err_cnt_q : (err_cnt_q + LOCK_CNT_ONE));
  assign lock_d = ~(pfd_busy & (err_cnt_q == LOCK_TOL_CYC));
  assign int_evt[INT_LOSS_BIT] = lock_q & ~lock_d;
  assign int_evt[INT_GAIN_BIT] = ~lock_q & lock_d;

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      err_cnt_q <= LOCK_CNT_ZERO;
      lock_q <= 1'b1;
    end else begin
      err_cnt_q <= err_cnt_d;
      lock_q <= lock_d;
    end
  end

  // ************************************************************
  // register bus and interrupt
  // ************************************************************
  logic [DATA_W-1:0] st_word;
  logic [DATA_W-1:0] rdata_q;
  logic irq_q;

  always_comb begin
    st_word = DATA_ZERO;
    st_word[ST_N_LSB +: SEL_W] = div_n;
    st_word[ST_LOCK_BIT] = lock_q;
    st_word[ST_UP_BIT] = pfd_q.up;
    st_word[ST_DN_BIT] = pfd_q.dn;
    st_word[ST_RATE_BIT] = REFERENCE_RATE_SELECT;
  end

  // unmapped and write-only offsets read as zero
  assign rd_mux = (REG_ADDR == OFS_CTRL) ? {{(DATA_W-1){1'b0}}, ctrl_en_q} :
    (REG_ADDR == OFS_STATE) ? st_word :
    (REG_ADDR == OFS_INT_STAT) ? {{(DATA_W-INT_W){1'b0}}, int_stat_q} :
    (REG_ADDR == OFS_INT_EN) ? {{(DATA_W-INT_W){1'b0}}, int_en_q} : DATA_ZERO;

  // read data stands only in the cycle after the strobe
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      ctrl_en_q <= CTRL_EN_RST;
      int_en_q <= INT_NONE;
      int_stat_q <= INT_NONE;
      rdata_q <= DATA_ZERO;
      irq_q <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl_en_q <= REG_WDATA[CTRL_EN_BIT];
      end
      if (wr_en) begin
        int_en_q <= REG_WDATA[INT_W-1:0];
      end
      int_stat_q <= int_stat_d;
      rdata_q <= REG_RD ? rd_mux : DATA_ZERO;
      irq_q <= |(int_stat_q & int_en_q);
    end
  end

  assign REG_RDATA = rdata_q;
  assign OSC_AMP_OUTPUT = osc_out_q;
  assign HALF_OSC_OUTPUT = half_q;
  assign PHASE_ERROR_O = out_q;
  assign PHASE_ERROR_OE = oe_q;
  assign LOCK_INDICATOR = lock_q;
  assign IRQ = irq_q;

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);

  sequence s_ref_quiet;
    !ref_tick_q [*8];
  endsequence

  sequence s_fb_quiet;
    !fb_tick [*2];
  endsequence

  property p_half_toggle;
    osc_rise |=> (HALF_OSC_OUTPUT != $past(HALF_OSC_OUTPUT));
  endproperty
  a_half_toggle: assert property (p_half_toggle) else $error("half rate missed a toggle");

  property p_half_hold;
    !osc_rise |=> $stable(HALF_OSC_OUTPUT);
  endproperty
  a_half_hold: assert property (p_half_hold) else $error("half rate moved without edge");

  property p_code_low;
    (CHANNEL_SELECT_INPUTS == SEL_CODE_ZERO) |-> (div_n == N_FOR_CODE_ZERO);
  endproperty
  a_code_low: assert property (p_code_low) else $error("code zero not divide by two");

  property p_fb_gap;
    fb_tick |=> s_fb_quiet;
  endproperty
  a_fb_gap: assert property (p_fb_gap) else $error("feedback ticks too close");

  property p_ref_gap;
    ref_tick_q |=> s_ref_quiet;
  endproperty
  a_ref_gap: assert property (p_ref_gap) else $error("reference ticks too close");

  property p_drive_high;
    (ref_tick_q && !fb_tick && !pfd_q.dn && ctrl_en_q) |=> (PHASE_ERROR_OE && PHASE_ERROR_O);
  endproperty
  a_drive_high: assert property (p_drive_high) else $error("lagging feedback not high");

  property p_drive_low;
    (fb_tick && !ref_tick_q && !pfd_q.up && ctrl_en_q) |=> (PHASE_ERROR_OE && !PHASE_ERROR_O);
  endproperty
  a_drive_low: assert property (p_drive_low) else $error("leading feedback not low");

  property p_coincide;
    (ref_tick_q && fb_tick && !pfd_q.up && !pfd_q.dn) |=> !PHASE_ERROR_OE;
  endproperty
  a_coincide: assert property (p_coincide) else $error("coincident edges drove pin");

  property p_lock_fall;
    $fell(LOCK_INDICATOR) |-> ($past(pfd_busy) && ($past(err_cnt_q) == LOCK_TOL_CYC));
  endproperty
  a_lock_fall: assert property (p_lock_fall) else $error("lock fell without long error");

  property p_lock_idle;
    !pfd_busy |=> LOCK_INDICATOR;
  endproperty
  a_lock_idle: assert property (p_lock_idle) else $error("lock low while detector idle");

endmodule

// [dv/psd_vco_model.sv]
`timescale 1ns/10ps
// stand-in for the external vco and its loop filter
module psd_vco_model (
  input wire logic clk,
  input wire logic clr,
  input wire logic [7:0] half_cyc,
  input wire logic pd_o,
  input wire logic pd_oe,
  output logic fb,
  output int rises,
  output int up_cyc,
  output int dn_cyc
);
  logic [7:0] cnt_q;
  logic run;
  logic wrap;
  logic fb_rise;

  // a zero half period is a stopped vco, parked low rather than frozen high
  assign run = (half_cyc != 8'h00);
  assign wrap = run && (cnt_q + 8'h01 >= half_cyc);
  assign fb_rise = wrap && !fb;

  initial fb = 1'b0;

  // vco: square wave of two half periods, each at least one clock long
  always @(posedge clk) begin
    if (clr || !run) begin
      cnt_q <= 8'h00;
      fb <= 1'b0;
    end else if (wrap) begin
      cnt_q <= 8'h00;
      fb <= ~fb;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end

  // loop filter: integrates pump time; a released pin adds nothing
  always @(posedge clk) begin
    if (clr) begin
      rises <= 0;
      up_cyc <= 0;
      dn_cyc <= 0;
    end else begin
      rises <= rises + int'(fb_rise);
      up_cyc <= up_cyc + int'(pd_oe === 1'b1 && pd_o === 1'b1);
      dn_cyc <= dn_cyc + int'(pd_oe === 1'b1 && pd_o === 1'b0);
    end
  end
endmodule

// [dv/psd_top_bench.sv]
`timescale 1ns/10ps
module psd_top_bench
  import psd_pkg::*;
;
  logic clk, rst, osc, osc_run, rate, rd, wr, clr;
  logic [SEL_W-1:0] sel;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata, rdata, rd_val;
  logic osc_out, half, pe_o, pe_oe, lock, irq, fb;
  logic [7:0] half_cyc;
  int rises, up_cyc, dn_cyc;
  int err_count = 0;
  int comparisons = 0;

  // ************************************************************
  // clock, oscillator and instances
  // ************************************************************
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // oscillator toggles every clock: one rise per two cycles
  always @(posedge clk) osc <= osc_run ? ~osc : 1'b0;

  psd_top uut (.REF_CLK(clk), .RST(rst), .OSC_AMP_INPUT(osc), .FEEDBACK_IN(fb),
    .CHANNEL_SELECT_INPUTS(sel), .REFERENCE_RATE_SELECT(rate), .REG_ADDR(addr),
    .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata),
    .OSC_AMP_OUTPUT(osc_out), .HALF_OSC_OUTPUT(half), .PHASE_ERROR_O(pe_o),
    .PHASE_ERROR_OE(pe_oe), .LOCK_INDICATOR(lock), .IRQ(irq));

  psd_vco_model vco (.clk(clk), .clr(clr), .half_cyc(half_cyc), .pd_o(pe_o),
    .pd_oe(pe_oe), .fb(fb), .rises(rises), .up_cyc(up_cyc), .dn_cyc(dn_cyc));

  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic print_verdict;
    if (err_count == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // ends just past the edge so that outputs are settled when sampled
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic setup(input logic [SEL_W-1:0] s, input logic r, input logic [7:0] h,
    input logic o);
    @(posedge clk);
    sel <= s;
    rate <= r;
    half_cyc <= h;
    osc_run <= o;
    rst <= 1'b1;
    clr <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    clr <= 1'b0;
    #1;
  endtask

  task automatic reg_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic reg_rd(input logic [ADDR_W-1:0] a);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    rd_val = rdata;
  endtask

  // bounded wait for the pump-up state; running out ends the run
  task automatic wait_up(output int cyc);
    cyc = 0;
    while (!(pe_oe === 1'b1 && pe_o === 1'b1) && cyc < 6000) begin
      step(1);
      cyc++;
    end
    if (cyc >= 6000) begin
      err_count++;
      print_verdict();
    end
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_reset;
    setup(9'h000, 1'b1, 8'h00, 1'b0);
    check("reset pins", 32'h12, {27'h0, osc_out, half, pe_oe, lock, irq});
    reg_rd(OFS_CTRL);
    check("ctrl reset", 32'h1, rd_val);
    reg_wr(8'h20, 32'hffff_ffff);
    reg_rd(8'h20);
    check("unmapped", 32'h0, rd_val);
    reg_rd(OFS_INT_CLR);
    check("clear reads zero", 32'h0, rd_val);
    step(1);
    check("rdata after read", 32'h0, rdata);
  endtask

  task automatic t_rate(input logic r, input int exp);
    int cyc;
    logic h;
    setup(9'h002, r, 8'h00, 1'b1);
    wait_up(cyc);
    check("ref delay", 32'h1, {31'h0, (cyc >= exp - 8 && cyc <= exp + 8)});
    h = half;
    step(2);
    check("half toggles", 32'h1, {31'h0, h ^ half});
    step(2);
    check("half period", 32'h0, {31'h0, h ^ half});
    // osc flips every edge, so the lagged inverse equals the present level
    check("amp inverts", {31'h0, osc}, {31'h0, osc_out});
    reg_rd(OFS_STATE);
    check("rate bit", {31'h0, r}, {31'h0, rd_val[ST_RATE_BIT]});
  endtask

  // only a feedback tick ends a pump-up pulse or starts a pump-down pulse,
  // so at either sight rises - 1 is a multiple of n
  task automatic t_div(input logic [SEL_W-1:0] s, input int n);
    int ev;
    logic prev;
    logic prev_oe;
    setup(s, 1'b1, 8'h03, 1'b1);
    reg_rd(OFS_STATE);
    check("effective n", n, {23'h0, rd_val[8:0]});
    ev = 0;
    prev = 1'b0;
    prev_oe = 1'b0;
    repeat (8000) begin
      step(1);
      if ((prev === 1'b1 && pe_o === 1'b0) ||
          (prev_oe === 1'b0 && pe_oe === 1'b1 && pe_o === 1'b0)) begin
        ev++;
        check("rises at tick", 32'h0, (rises - 1) % n);
      end
      prev = pe_o;
      prev_oe = pe_oe;
    end
    check("tick events", 32'h1, {31'h0, ev >= 2});
  endtask

  task automatic t_pump;
    setup(9'h002, 1'b1, 8'h02, 1'b1);
    step(5000);
    check("pump down", 32'h1, {31'h0, dn_cyc > 4 * up_cyc});
    setup(9'h1ff, 1'b1, 8'h00, 1'b1);
    step(100);
    check("lock idle", 32'h1, {31'h0, lock});
    step(4900);
    check("pump up", 32'h1, {31'h0, up_cyc > 0 && dn_cyc == 0});
    check("lock lost", 32'h0, {31'h0, lock});
    reg_rd(OFS_INT_STAT);
    check("loss event", 32'h1, rd_val);
    check("irq masked", 32'h0, {31'h0, irq});
    reg_wr(OFS_INT_EN, 32'h1);
    step(2);
    check("irq on", 32'h1, {31'h0, irq});
    reg_wr(OFS_INT_EN, 32'h0);
    step(2);
    check("irq off", 32'h0, {31'h0, irq});
    reg_wr(OFS_INT_EN, 32'h1);
    reg_wr(OFS_INT_CLR, 32'h1);
    step(2);
    check("irq cleared", 32'h0, {31'h0, irq});
    reg_rd(OFS_INT_STAT);
    check("stat cleared", 32'h0, rd_val);
    // restart the vco: its first tick ends the long pump-up pulse
    @(posedge clk);
    half_cyc <= 8'h02;
    step(20);
    check("lock regained", 32'h1, {31'h0, lock});
    reg_rd(OFS_INT_STAT);
    check("gain event", 32'h2, rd_val);
  endtask

  // a disabled detector must leave the loop filter pin released
  task automatic t_disable;
    setup(9'h002, 1'b1, 8'h00, 1'b1);
    reg_wr(OFS_CTRL, 32'h0);
    step(2500);
    check("pin released", 32'h0, up_cyc + dn_cyc);
    reg_rd(OFS_CTRL);
    check("ctrl written", 32'h0, rd_val);
  endtask

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    rst = 1'b1;
    clr = 1'b1;
    osc = 1'b0;
    osc_run = 1'b0;
    rate = 1'b1;
    rd = 1'b0;
    wr = 1'b0;
    sel = 9'h000;
    addr = 8'h00;
    wdata = 32'h0;
    half_cyc = 8'h00;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    clr <= 1'b0;
    t_reset();
    t_rate(1'b1, 2048);
    t_rate(1'b0, 4096);
    t_div(9'h000, 2);
    t_div(9'h001, 3);
    t_div(9'h002, 2);
    t_div(9'h007, 7);
    t_div(9'h1ff, 511);
    t_pump();
    t_disable();
    print_verdict();
  end
endmodule
